// File: hw/jbs_dev.sv
// device end: tap controller, instruction register and boundary register
// tap logic runs on tck; pin muxing runs on ref_clk_i; words cross by toggle handshake
`include "jbs_consts.svh"
module jbs_dev
   import jbs_pkg::*;
#(
   parameter int N_IN  = `JBS_N_IN,
   parameter int N_OUT = `JBS_N_OUT
) (
   input  wire logic             ref_clk_i,           // core clock
   input  wire logic             reset_i,             // core reset, sync, high
   jbs_if.dev                    jtag,                // jtag port
   input  wire logic [N_IN-1:0]  pad_in_i,            // board level of input pins
   input  wire logic             crystal_input_pin_i, // crystal input pin level
   input  wire logic             bus_clock_pin_i,     // bus clock pin level
   output logic      [N_IN-1:0]  core_in_o,           // input pins to the core
   input  wire logic [N_OUT-1:0] core_out_i,          // core output values
   input  wire logic [N_OUT-1:0] core_oe_i,           // core output enables
   output logic      [N_OUT-1:0] pad_out_o,           // output pin values
   output logic      [N_OUT-1:0] pad_oe_o,            // output pin enables
   input  wire logic             standby_i,           // core in standby
   output logic                  bscan_mode_o,        // boundary scan instruction loaded
   output logic                  dbg_int_o            // debug interrupt pulse
);
   localparam int NI = N_IN + 2;
   localparam int L  = NI + 2 * N_OUT;

   function automatic jbs_tap_t tap_next(input jbs_tap_t s, input logic tms);
      case (s)
         JBS_TLR:   tap_next = tms ? JBS_TLR   : JBS_IDLE;
         JBS_IDLE:  tap_next = tms ? JBS_SELDR : JBS_IDLE;
         JBS_SELDR: tap_next = tms ? JBS_SELIR : JBS_CAPDR;
         JBS_CAPDR: tap_next = tms ? JBS_EX1DR : JBS_SHDR;
         JBS_SHDR:  tap_next = tms ? JBS_EX1DR : JBS_SHDR;
         JBS_EX1DR: tap_next = tms ? JBS_UPDR  : JBS_PSDR;
         JBS_PSDR:  tap_next = tms ? JBS_EX2DR : JBS_PSDR;
         JBS_EX2DR: tap_next = tms ? JBS_UPDR  : JBS_SHDR;
         JBS_UPDR:  tap_next = tms ? JBS_SELDR : JBS_IDLE;
         JBS_SELIR: tap_next = tms ? JBS_TLR   : JBS_CAPIR;
         JBS_CAPIR: tap_next = tms ? JBS_EX1IR : JBS_SHIR;
         JBS_SHIR:  tap_next = tms ? JBS_EX1IR : JBS_SHIR;
         JBS_EX1IR: tap_next = tms ? JBS_UPIR  : JBS_PSIR;
         JBS_PSIR:  tap_next = tms ? JBS_EX2IR : JBS_PSIR;
         JBS_EX2IR: tap_next = tms ? JBS_UPIR  : JBS_SHIR;
         JBS_UPIR:  tap_next = tms ? JBS_SELDR : JBS_IDLE;
         default:   tap_next = JBS_TLR;
      endcase
   endfunction

   // tck domain
   jbs_tap_t              tap_q, tap_d;
   logic [`JBS_IR_W-1:0]  ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic [L-1:0]          bsr_q, bsr_d;
   logic                  byp_q, byp_d;
   logic [2*N_OUT-1:0]    upd_q, upd_d;
   logic                  upd_tgl_q, upd_tgl_d, int_tgl_q, int_tgl_d;
   logic                  ext_q, ext_d, mode_q, mode_d;
   logic [NI-1:0]         tpin_s1_q, tpin_s2_q;
   logic [N_OUT-1:0]      tco_s1_q, tco_s2_q, toe_s1_q, toe_s2_q;
   logic                  stby_q, stby_s1_q, stby_s2_q;
   logic                  tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
   logic                  bsr_sel;

   // capture happens on tck, so pin and core levels are synchronised to it first
   always_ff @(posedge jtag.tck or negedge jtag.trst_n) begin
      if (!jtag.trst_n) begin
         tap_q     <= JBS_TLR;
         ir_sh_q   <= `JBS_IR_CAPTURE;
         ir_q      <= `JBS_IR_BYPASS;
         bsr_q     <= '0;
         byp_q     <= 1'b0;
         upd_q     <= {{N_OUT{1'b1}}, {N_OUT{1'b0}}};
         upd_tgl_q <= 1'b0;
         int_tgl_q <= 1'b0;
         ext_q     <= 1'b0;
         mode_q    <= 1'b0;
         tpin_s1_q <= '0;
         tpin_s2_q <= '0;
         tco_s1_q  <= '0;
         tco_s2_q  <= '0;
         toe_s1_q  <= '0;
         toe_s2_q  <= '0;
         stby_s1_q <= 1'b0;
         stby_s2_q <= 1'b0;
      end else begin
         tap_q     <= tap_d;
         ir_sh_q   <= ir_sh_d;
         ir_q      <= ir_d;
         bsr_q     <= bsr_d;
         byp_q     <= byp_d;
         upd_q     <= upd_d;
         upd_tgl_q <= upd_tgl_d;
         int_tgl_q <= int_tgl_d;
         ext_q     <= ext_d;
         mode_q    <= mode_d;
         tpin_s1_q <= {pad_in_i, bus_clock_pin_i, crystal_input_pin_i};
         tpin_s2_q <= tpin_s1_q;
         tco_s1_q  <= core_out_i;
         tco_s2_q  <= tco_s1_q;
         toe_s1_q  <= core_oe_i;
         toe_s2_q  <= toe_s1_q;
         stby_s1_q <= stby_q;
         stby_s2_q <= stby_s1_q;
      end
   end

   assign bsr_sel = (ir_q == `JBS_IR_SAMPLE) || (ir_q == `JBS_IR_EXTEST);

   always_comb begin
      tap_d     = tap_next(tap_q, jtag.tms);
      ir_sh_d   = ir_sh_q;
      ir_d      = ir_q;
      bsr_d     = bsr_q;
      byp_d     = byp_q;
      upd_d     = upd_q;
      upd_tgl_d = upd_tgl_q;
      int_tgl_d = int_tgl_q;
      case (tap_q)
         JBS_CAPIR: ir_sh_d = `JBS_IR_CAPTURE;
         JBS_SHIR:  ir_sh_d = {jtag.tdi, ir_sh_q[`JBS_IR_W-1:1]};
         JBS_UPIR: begin
            if (!stby_s2_q) begin
               if (ir_sh_q == `JBS_IR_INT) begin
                  ir_d      = `JBS_IR_BYPASS;
                  int_tgl_d = ~int_tgl_q;
               end else begin
                  ir_d = ir_sh_q;
               end
            end
         end
         JBS_CAPDR: begin
            byp_d = 1'b0;
            // output cells take core values even under extest; the shift replaces them
            if (bsr_sel) begin
               bsr_d = {~toe_s2_q, tco_s2_q, tpin_s2_q};
            end
         end
         JBS_SHDR: begin
            byp_d = jtag.tdi;
            if (bsr_sel) begin
               bsr_d = {jtag.tdi, bsr_q[L-1:1]};
            end
         end
         JBS_UPDR: begin
            if (bsr_sel) begin
               upd_d     = bsr_q[L-1:NI];
               upd_tgl_d = ~upd_tgl_q;
            end
         end
         default: ;
      endcase
      ext_d  = (ir_d == `JBS_IR_EXTEST);
      mode_d = (ir_d == `JBS_IR_EXTEST) || (ir_d == `JBS_IR_SAMPLE);
      tdo_oe_d = (tap_q == JBS_SHDR) || (tap_q == JBS_SHIR);
      if (tap_q == JBS_SHIR) begin
         tdo_d = ir_sh_q[0];
      end else if (bsr_sel) begin
         tdo_d = bsr_q[0];
      end else begin
         tdo_d = byp_q;
      end
   end

   always_ff @(negedge jtag.tck or negedge jtag.trst_n) begin
      if (!jtag.trst_n) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q    <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
      end
   end

   assign jtag.tdo    = tdo_q;
   assign jtag.tdo_oe = tdo_oe_q;

   // ref_clk domain
   // the latch word is stable for a whole dr scan after each toggle, so it is copied safely
   logic [N_IN-1:0]    pin_s1_q, pin_s2_q;
   logic               ext_s1_q, ext_s2_q, mode_s1_q, mode_s2_q;
   logic [2:0]         ut_q, it_q;
   logic [2*N_OUT-1:0] lat_q, lat_d;
   logic [N_OUT-1:0]   pout_q, pout_d, poe_q, poe_d;
   logic               int_q;

   always_comb begin
      lat_d = (ut_q[2] != ut_q[1]) ? upd_q : lat_q;
      if (ext_s2_q) begin
         pout_d = lat_q[N_OUT-1:0];
         poe_d  = ~lat_q[2*N_OUT-1:N_OUT];
      end else begin
         pout_d = core_out_i;
         poe_d  = core_oe_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pin_s1_q  <= '0;
         pin_s2_q  <= '0;
         ext_s1_q  <= 1'b0;
         ext_s2_q  <= 1'b0;
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
         ut_q      <= 3'h0;
         it_q      <= 3'h0;
         lat_q     <= {{N_OUT{1'b1}}, {N_OUT{1'b0}}};
         pout_q    <= '0;
         poe_q     <= '0;
         int_q     <= 1'b0;
         stby_q    <= 1'b0;
      end else begin
         pin_s1_q  <= pad_in_i;
         pin_s2_q  <= pin_s1_q;
         ext_s1_q  <= ext_q;
         ext_s2_q  <= ext_s1_q;
         mode_s1_q <= mode_q;
         mode_s2_q <= mode_s1_q;
         ut_q      <= {ut_q[1:0], upd_tgl_q};
         it_q      <= {it_q[1:0], int_tgl_q};
         lat_q     <= lat_d;
         pout_q    <= pout_d;
         poe_q     <= poe_d;
         int_q     <= it_q[2] != it_q[1];
         stby_q    <= standby_i;
      end
   end

   assign core_in_o    = pin_s2_q;
   assign pad_out_o    = pout_q;
   assign pad_oe_o     = poe_q;
   assign bscan_mode_o = mode_s2_q;
   assign dbg_int_o    = int_q;
endmodule

// File: hw/jbs_consts.svh
// constants shared by both ends of the boundary scan link
// assumes a 100 MHz ref_clk_i on the host end and a 12.5 MHz TCK, 40 ns per half period
// Overview of operation
// - boundary scan instruction puts pins in scan mode
// - bypass code 1111, one-stage bypass register
// - bypass leaves functional circuitry untouched
// - sample/preload code is 0100
// - sample/preload passes pins and core through unchanged
// - sample latches snapshot at capture-dr rising tck
// - preload loads shifted data into output latch
// - controller preloads latch before selecting extest
// - extest code is 0000
// - extest drives output pins from latch
// - extest captures board inputs into boundary register
// - next pattern shifts in while results shift out
// - output cells captured under extest get overwritten
// - chain includes crystal and bus clock pins
// - chain excludes reset and chip-active pins
// - chain excludes the jtag port pins
// - tester holds chip-active high, mode low, reset low
// - loaded command persists until another is issued
// - interrupt command reverts to bypass after load
// - standby ignores commands, tap keeps running
// - tms and tdi sampled on rising tck
// - tdo changes on falling tck, else off
// - trst low resets tap asynchronously
`ifndef JBS_CONSTS_SVH
`define JBS_CONSTS_SVH

`define JBS_IR_W          4
`define JBS_IR_BYPASS     4'hf
`define JBS_IR_SAMPLE     4'h4
`define JBS_IR_EXTEST     4'h0
`define JBS_IR_INT        4'h5
`define JBS_IR_CAPTURE    4'h1

`define JBS_N_IN          8
`define JBS_N_OUT         8
`define JBS_MAX_LEN       64

// host tms sequences, sent lsb first
`define JBS_PAT_INIT      8'h1f
`define JBS_LEN_INIT      6
`define JBS_PAT_DR        8'h01
`define JBS_LEN_DR        3
`define JBS_PAT_IR        8'h03
`define JBS_LEN_IR        4
`define JBS_PAT_POST      8'h01
`define JBS_LEN_POST      2

`define JBS_REF_PERIOD_NS 10
`define JBS_TCK_HALF_NS   40
`define JBS_TCK_HALF_CYC  (`JBS_TCK_HALF_NS / `JBS_REF_PERIOD_NS)

`endif

// File: hw/jbs_pkg.sv
// types shared by both ends of the boundary scan link
// assumes jbs_consts.svh is on the include path
package jbs_pkg;
   typedef enum logic [3:0] {
      JBS_TLR   = 4'h0,
      JBS_IDLE  = 4'h1,
      JBS_SELDR = 4'h2,
      JBS_CAPDR = 4'h3,
      JBS_SHDR  = 4'h4,
      JBS_EX1DR = 4'h5,
      JBS_PSDR  = 4'h6,
      JBS_EX2DR = 4'h7,
      JBS_UPDR  = 4'h8,
      JBS_SELIR = 4'h9,
      JBS_CAPIR = 4'ha,
      JBS_SHIR  = 4'hb,
      JBS_EX1IR = 4'hc,
      JBS_PSIR  = 4'hd,
      JBS_EX2IR = 4'he,
      JBS_UPIR  = 4'hf
   } jbs_tap_t;

   typedef enum logic [2:0] {
      JBS_H_INIT  = 3'h0,
      JBS_H_IDLE  = 3'h1,
      JBS_H_PRE   = 3'h2,
      JBS_H_SHIFT = 3'h3,
      JBS_H_POST  = 3'h4,
      JBS_H_DONE  = 3'h5
   } jbs_host_st_t;
endpackage

// File: hw/jbs_if.sv
// jtag wires between the test controller and the scanned device
// tdo is open when not enabled; the line models a pull-up
interface jbs_if;
   logic tck;
   logic tms;
   logic tdi;
   logic trst_n;
   logic tdo;
   logic tdo_oe;
   logic tdo_line;

   assign tdo_line = tdo_oe ? tdo : 1'b1;

   modport dev (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
   modport host (output tck, output tms, output tdi, output trst_n, input tdo_line);
endinterface

// File: hw/jbs_host.sv
// test controller end: makes tck by dividing ref_clk_i and runs ir/dr scans
// assumes the device tap starts anywhere; it is walked to idle after reset
`include "jbs_consts.svh"
module jbs_host
   import jbs_pkg::*;
#(
   parameter int W    = `JBS_MAX_LEN,
   parameter int HALF = `JBS_TCK_HALF_CYC,
   parameter int LW   = $clog2(W + 1)
) (
   input  wire logic          ref_clk_i,   // clock
   input  wire logic          reset_i,     // sync reset, high
   jbs_if.host                jtag,        // jtag port
   input  wire logic          trst_req_i,  // hold tap in reset
   input  wire logic          cmd_valid_i, // scan request
   input  wire logic          cmd_ir_i,    // 1 ir scan, 0 dr scan
   input  wire logic [LW-1:0] cmd_len_i,   // bits to shift, 1..W
   input  wire logic [W-1:0]  cmd_data_i,  // bits to send, lsb first
   output logic               cmd_ready_o, // request accepted when high
   output logic               rsp_valid_o, // result pulse
   output logic [W-1:0]       rsp_data_o   // captured bits, lsb first
);
   jbs_host_st_t st_q, st_d;
   logic [7:0]   div_q, div_d, pat_q, pat_d;
   logic [LW-1:0] cnt_q, cnt_d, len_q, len_d;
   logic [W-1:0] dat_q, dat_d, rsp_q, rsp_d, rout_q, rout_d;
   logic         tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d, trst_n_q;
   logic         smp_q, smp_d, rdy_q, rdy_d, rv_q, rv_d;
   logic         tdo_s1_q, tdo_s2_q;
   logic         tick, fall, rise;

   assign tick = (div_q == 8'(HALF - 1));
   assign fall = tick && tck_q;
   assign rise = tick && !tck_q;

   always_comb begin
      div_d  = tick ? 8'h00 : div_q + 8'h01;
      tck_d  = tick ? ~tck_q : tck_q;
      st_d   = st_q;
      pat_d  = pat_q;
      cnt_d  = cnt_q;
      len_d  = len_q;
      dat_d  = dat_q;
      rsp_d  = rsp_q;
      rout_d = rout_q;
      tms_d  = tms_q;
      tdi_d  = tdi_q;
      smp_d  = smp_q;
      rdy_d  = rdy_q;
      rv_d   = 1'b0;
      // tdo was launched on the previous falling edge; the sync delay fits in half a period
      if (rise && smp_q) begin
         rsp_d = {tdo_s2_q, rsp_q[W-1:1]};
      end
      case (st_q)
         JBS_H_INIT, JBS_H_PRE, JBS_H_POST: begin
            if (fall) begin
               smp_d = 1'b0;
               tms_d = pat_q[0];
               pat_d = pat_q >> 1;
               cnt_d = cnt_q - LW'(1);
               if (cnt_q == LW'(1)) begin
                  if (st_q == JBS_H_INIT) begin
                     st_d  = JBS_H_IDLE;
                     rdy_d = 1'b1;
                  end else if (st_q == JBS_H_PRE) begin
                     st_d  = JBS_H_SHIFT;
                     cnt_d = len_q;
                  end else begin
                     st_d = JBS_H_DONE;
                  end
               end
            end
         end
         JBS_H_IDLE: begin
            if (cmd_valid_i) begin
               st_d  = JBS_H_PRE;
               rdy_d = 1'b0;
               len_d = cmd_len_i;
               dat_d = cmd_data_i;
               rsp_d = '0;
               pat_d = cmd_ir_i ? `JBS_PAT_IR : `JBS_PAT_DR;
               cnt_d = cmd_ir_i ? LW'(`JBS_LEN_IR) : LW'(`JBS_LEN_DR);
            end
         end
         JBS_H_SHIFT: begin
            if (fall) begin
               smp_d = 1'b1;
               tms_d = (cnt_q == LW'(1));
               tdi_d = dat_q[0];
               dat_d = dat_q >> 1;
               cnt_d = cnt_q - LW'(1);
               if (cnt_q == LW'(1)) begin
                  st_d  = JBS_H_POST;
                  pat_d = `JBS_PAT_POST;
                  cnt_d = LW'(`JBS_LEN_POST);
               end
            end
         end
         JBS_H_DONE: begin
            st_d   = JBS_H_IDLE;
            rdy_d  = 1'b1;
            rv_d   = 1'b1;
            rout_d = rsp_q >> (W - int'(len_q));
         end
         default: st_d = JBS_H_INIT;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || trst_req_i) begin
         st_q   <= JBS_H_INIT;
         div_q  <= 8'h00;
         pat_q  <= `JBS_PAT_INIT;
         cnt_q  <= LW'(`JBS_LEN_INIT);
         len_q  <= '0;
         dat_q  <= '0;
         rsp_q  <= '0;
         rout_q <= '0;
         tck_q  <= 1'b0;
         tms_q  <= 1'b1;
         tdi_q  <= 1'b0;
         smp_q  <= 1'b0;
         rdy_q  <= 1'b0;
         rv_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         div_q  <= div_d;
         pat_q  <= pat_d;
         cnt_q  <= cnt_d;
         len_q  <= len_d;
         dat_q  <= dat_d;
         rsp_q  <= rsp_d;
         rout_q <= rout_d;
         tck_q  <= tck_d;
         tms_q  <= tms_d;
         tdi_q  <= tdi_d;
         smp_q  <= smp_d;
         rdy_q  <= rdy_d;
         rv_q   <= rv_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         trst_n_q <= 1'b0;
         tdo_s1_q <= 1'b1;
         tdo_s2_q <= 1'b1;
      end else begin
         trst_n_q <= ~trst_req_i;
         tdo_s1_q <= jtag.tdo_line;
         tdo_s2_q <= tdo_s1_q;
      end
   end

   assign jtag.tck    = tck_q;
   assign jtag.tms    = tms_q;
   assign jtag.tdi    = tdi_q;
   assign jtag.trst_n = trst_n_q;
   assign cmd_ready_o = rdy_q;
   assign rsp_valid_o = rv_q;
   assign rsp_data_o  = rout_q;
endmodule

// File: dv/jbs_chk.sv
// concurrent checks on the jtag wires between host and device
// assumes a 4-bit instruction register and the default boundary chain length
module jbs_chk
   import jbs_pkg::*;
#(
   parameter int CHAIN = 26
) (
   input wire logic tck,     // link clock
   input wire logic tms,     // mode select
   input wire logic tdi,     // data to device
   input wire logic trst_n,  // tap reset, low active
   input wire logic tdo,     // device data out
   input wire logic tdo_oe,  // device drives tdo
   input wire logic tdo_line // resolved tdo wire
);
   timeunit 1ns;
   timeprecision 100ps;

   jbs_tap_t         st_q, st_d;
   logic [3:0]       ir_q, ir_d, irs_q, irs_d;
   logic [6:0]       cnt_q, cnt_d;
   logic [CHAIN-1:0] hist_q, hist_d;
   logic             rise_tdo_q, shift, byp;

   function automatic jbs_tap_t nx(input jbs_tap_t s, input logic m);
      case (s)
         JBS_TLR:   return m ? JBS_TLR : JBS_IDLE;
         JBS_IDLE:  return m ? JBS_SELDR : JBS_IDLE;
         JBS_SELDR: return m ? JBS_SELIR : JBS_CAPDR;
         JBS_CAPDR: return m ? JBS_EX1DR : JBS_SHDR;
         JBS_SHDR:  return m ? JBS_EX1DR : JBS_SHDR;
         JBS_EX1DR: return m ? JBS_UPDR : JBS_PSDR;
         JBS_PSDR:  return m ? JBS_EX2DR : JBS_PSDR;
         JBS_EX2DR: return m ? JBS_UPDR : JBS_SHDR;
         JBS_SELIR: return m ? JBS_TLR : JBS_CAPIR;
         JBS_CAPIR: return m ? JBS_EX1IR : JBS_SHIR;
         JBS_SHIR:  return m ? JBS_EX1IR : JBS_SHIR;
         JBS_EX1IR: return m ? JBS_UPIR : JBS_PSIR;
         JBS_PSIR:  return m ? JBS_EX2IR : JBS_PSIR;
         JBS_EX2IR: return m ? JBS_UPIR : JBS_SHIR;
         default:   return m ? JBS_SELDR : JBS_IDLE;
      endcase
   endfunction

   // the model ignores standby, so the bench never shifts data while the two disagree
   always_comb begin
      st_d = nx(st_q, tms);
      shift = st_q == JBS_SHDR || st_q == JBS_SHIR;
      cnt_d = shift ? cnt_q + 7'h01 : 7'h00;
      hist_d = shift ? {hist_q[CHAIN-2:0], tdi} : hist_q;
      irs_d = st_q == JBS_SHIR ? {tdi, irs_q[3:1]} : irs_q;
      ir_d = st_q == JBS_UPIR ? irs_q : ir_q;
      byp = ir_q != 4'h0 && ir_q != 4'h4;
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         st_q <= JBS_TLR;
         ir_q <= 4'hf;
         irs_q <= 4'h0;
         cnt_q <= 7'h00;
         hist_q <= '0;
      end else begin
         st_q <= st_d;
         ir_q <= ir_d;
         irs_q <= irs_d;
         cnt_q <= cnt_d;
         hist_q <= hist_d;
      end
   end

   always_ff @(posedge tck) begin
      rise_tdo_q <= tdo;
   end

   oe_shift_a: assert property (@(posedge tck) disable iff (!trst_n) tdo_oe == shift)
      else $error("tdo enable outside shift states");
   tdo_hold_a: assert property (@(negedge tck) disable iff (!trst_n) tdo_oe |-> tdo == rise_tdo_q)
      else $error("tdo moved on a rising edge");
   ir_cap_a: assert property (@(posedge tck) disable iff (!trst_n)
      st_q == JBS_SHIR && cnt_q < 7'h04 |-> tdo == (cnt_q == 7'h00))
      else $error("instruction capture value wrong");
   ir_path_a: assert property (@(posedge tck) disable iff (!trst_n)
      st_q == JBS_SHIR && cnt_q >= 7'h04 |-> tdo == hist_q[3])
      else $error("instruction path not four stages");
   byp_first_a: assert property (@(posedge tck) disable iff (!trst_n)
      st_q == JBS_SHDR && byp && cnt_q == 7'h00 |-> !tdo)
      else $error("bypass stage did not capture zero");
   byp_path_a: assert property (@(posedge tck) disable iff (!trst_n)
      st_q == JBS_SHDR && byp && cnt_q != 7'h00 |-> tdo == hist_q[0])
      else $error("bypass path not one stage");
   chain_len_a: assert property (@(posedge tck) disable iff (!trst_n)
      st_q == JBS_SHDR && !byp && cnt_q >= CHAIN |-> tdo == hist_q[CHAIN-1])
      else $error("boundary chain length wrong");
   tlr_off_a: assert property (@(posedge tck) disable iff (!trst_n) tms [*5] |=> !tdo_oe)
      else $error("tdo driven after five mode-select ones");
   line_idle_a: assert property (@(posedge tck) disable iff (!trst_n) !shift |-> tdo_line)
      else $error("tdo line not released outside shift states");
endmodule

// File: dv/jtag_boundary_scan_unit_tb.sv
// self-checking bench: host and device joined by jbs_if, checker beside the link
// assumes HALF of 4 on the host, so one tck period is 8 reference cycles
module jtag_boundary_scan_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk_i = 1'b0, reset_i = 1'b1, trst_req_i, cmd_valid_i, cmd_ir_i, standby_i;
   logic        crystal_input_pin_i, bus_clock_pin_i, cmd_ready_o, rsp_valid_o, bscan_mode_o, dbg_int_o;
   logic [6:0]  cmd_len_i;
   logic [63:0] cmd_data_i, rsp_data_o, got, p;
   logic [7:0]  pad_in_i, core_in_o, core_out_i, core_oe_i, pad_out_o, pad_oe_o;
   logic [31:0] lfsr_q = 32'h0001_6547;
   logic [25:0] lat;
   logic [3:0]  codes [5] = '{4'hf, 4'h3, 4'ha, 4'h5, 4'he};
   int          n_mismatch, check_count, n_int, cyc;

   jbs_if link();

   jbs_host #(.HALF(4)) jbs_host_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .jtag(link.host),
      .trst_req_i(trst_req_i), .cmd_valid_i(cmd_valid_i), .cmd_ir_i(cmd_ir_i), .cmd_len_i(cmd_len_i),
      .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
   jbs_dev jbs_dev_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .jtag(link.dev), .pad_in_i(pad_in_i),
      .crystal_input_pin_i(crystal_input_pin_i), .bus_clock_pin_i(bus_clock_pin_i), .core_in_o(core_in_o),
      .core_out_i(core_out_i), .core_oe_i(core_oe_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
      .standby_i(standby_i), .bscan_mode_o(bscan_mode_o), .dbg_int_o(dbg_int_o));
   jbs_chk #(.CHAIN(26)) jbs_chk_inst (.tck(link.tck), .tms(link.tms), .tdi(link.tdi), .trst_n(link.trst_n),
      .tdo(link.tdo), .tdo_oe(link.tdo_oe), .tdo_line(link.tdo_line));

   always #5 ref_clk_i = ~ref_clk_i;

   task automatic report_and_stop;
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ceiling is several times the expected run of about 3400 cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (dbg_int_o === 1'b1) n_int++;
      if (cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [63:0] byp_exp(input logic [63:0] d, input int len);
      return (d << 1) & ((64'h1 << len) - 64'h1);
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pins;
      lfsr_q = nxt(lfsr_q);
      {bus_clock_pin_i, crystal_input_pin_i, core_oe_i, core_out_i, pad_in_i} = lfsr_q[25:0];
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   task automatic scan(input logic ir, input int len, input logic [63:0] d);
      @(negedge ref_clk_i);
      while (cmd_ready_o !== 1'b1) begin
         @(negedge ref_clk_i);
      end
      cmd_ir_i = ir;
      cmd_len_i = 7'(len);
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      @(negedge ref_clk_i);
      cmd_valid_i = 1'b0;
      while (rsp_valid_o !== 1'b1) begin
         @(negedge ref_clk_i);
      end
      got = rsp_data_o;
   endtask

   task automatic thru;
      chk({pad_out_o, pad_oe_o, core_in_o}, {core_out_i, core_oe_i, pad_in_i});
   endtask

   initial begin
      {trst_req_i, cmd_valid_i, cmd_ir_i, standby_i, cmd_len_i, cmd_data_i} = '0;
      pins();
      settle(8);
      reset_i = 1'b0;
      // bypass, unknown codes and the interrupt code all leave a one-stage path
      for (int i = 0; i < 5; i++) begin
         scan(1'b1, 4, {60'h0, codes[i]});
         chk(got, 64'h1);
         lfsr_q = nxt(lfsr_q);
         scan(1'b0, 33, {32'h0, lfsr_q});
         chk(got, byp_exp({32'h0, lfsr_q}, 33));
         pins();
         settle(8);
         thru();
         chk(bscan_mode_o, 1'b0);
      end
      chk(n_int, 1);
      scan(1'b1, 4, 64'h4);
      pins();
      settle(8);
      chk(bscan_mode_o, 1'b1);
      thru();
      lfsr_q = nxt(lfsr_q);
      p = {24'h0, lfsr_q[7:0], nxt(lfsr_q)};
      scan(1'b0, 40, p);
      chk(got[25:0], {~core_oe_i, core_out_i, pad_in_i, bus_clock_pin_i, crystal_input_pin_i});
      chk(got[39:26], p[13:0]);
      lat = p[39:14];
      settle(8);
      thru();
      scan(1'b1, 4, 64'h0);
      settle(8);
      chk({pad_out_o, pad_oe_o}, {lat[17:10], ~lat[25:18]});
      pins();
      settle(8);
      chk({pad_out_o, pad_oe_o}, {lat[17:10], ~lat[25:18]});
      lfsr_q = nxt(lfsr_q);
      scan(1'b0, 26, {38'h0, lfsr_q[25:0]});
      chk(got[9:0], {pad_in_i, bus_clock_pin_i, crystal_input_pin_i});
      lat = lfsr_q[25:0];
      settle(8);
      chk({pad_out_o, pad_oe_o}, {lat[17:10], ~lat[25:18]});
      standby_i = 1'b1;
      settle(20);
      scan(1'b1, 4, 64'hf);
      chk(got, 64'h1);
      settle(20);
      chk({bscan_mode_o, pad_out_o, pad_oe_o}, {1'b1, lat[17:10], ~lat[25:18]});
      standby_i = 1'b0;
      settle(20);
      scan(1'b1, 4, 64'hf);
      settle(8);
      chk(bscan_mode_o, 1'b0);
      thru();
      scan(1'b1, 4, 64'h4);
      settle(8);
      chk(bscan_mode_o, 1'b1);
      trst_req_i = 1'b1;
      settle(8);
      chk({link.trst_n, link.tdo_oe, bscan_mode_o}, 3'b000);
      trst_req_i = 1'b0;
      scan(1'b1, 4, 64'hf);
      chk(got, 64'h1);
      report_and_stop();
   end
endmodule
